// ==== ait_pkg.sv ====
// constants, types and the timing table for the alu instruction timer
// assumes a single core clock; used by ait_alu_timing and ait_timing_rom
`default_nettype none
package ait_pkg;

    localparam int AIT_ADDR_TIME_W = 8;
    localparam int AIT_TOTAL_W     = 7;
    localparam int AIT_CNT_W       = 9;
    localparam int AIT_BUS_W       = 2;
    localparam int AIT_OP_W        = 5;

    localparam logic [AIT_CNT_W-1:0] AIT_MIN_SPAN = 9'h001;
    localparam logic [AIT_CNT_W-1:0] AIT_PF_BACK  = 9'h002;
    localparam logic [AIT_CNT_W-1:0] AIT_WR_BACK  = 9'h001;
    localparam logic [AIT_BUS_W-1:0] AIT_ONE_PF   = 2'h1;
    localparam logic [AIT_BUS_W-1:0] AIT_NO_PF    = 2'h0;

    typedef enum logic [AIT_OP_W-1:0] {
        AIT_OP_REG_ALU,
        AIT_OP_MEM_ALU,
        AIT_OP_ADDR_COMPARE,
        AIT_OP_BOUNDS_CHECK,
        AIT_OP_WORD_MULTIPLY,
        AIT_OP_LONG_MULTIPLY,
        AIT_OP_UNSIGNED_WORD_DIVIDE,
        AIT_OP_UNSIGNED_LONG_DIVIDE,
        AIT_OP_SIGNED_WORD_DIVIDE,
        AIT_OP_SIGNED_LONG_DIVIDE,
        AIT_OP_DECIMAL_REG,
        AIT_OP_DECIMAL_MEM,
        AIT_OP_EXTEND_REG,
        AIT_OP_EXTEND_MEM,
        AIT_OP_MEM_COMPARE,
        AIT_OP_BCD_PACK_REG,
        AIT_OP_BCD_UNPACK_REG,
        AIT_OP_BCD_PACK_MEM
    } ait_op_t;

    typedef enum logic [1:0] {
        AIT_CASE_BEST,
        AIT_CASE_CACHE,
        AIT_CASE_WORST
    } ait_case_t;

    typedef struct packed {
        logic                   add_time;
        logic [AIT_TOTAL_W-1:0] total;
        logic [AIT_BUS_W-1:0]   rd;
        logic [AIT_BUS_W-1:0]   pf;
        logic [AIT_BUS_W-1:0]   wr;
    } ait_entry_t;

    // row: add-address-time, best, cache, worst, reads, writes
    function automatic ait_entry_t ait_lookup(input logic [AIT_OP_W-1:0] op,
                                              input logic [1:0]          cse);
        logic [25:0] row;
        ait_entry_t  e;
        row = {1'h1, 7'h00, 7'h02, 7'h03, 2'h0, 2'h0};
        unique case (op)
            // RQ4 RQ14 register destination ops
            AIT_OP_REG_ALU:              row = {1'h1, 7'h00, 7'h02, 7'h03, 2'h0, 2'h0};
            // RQ5 RQ15 memory destination write
            AIT_OP_MEM_ALU:              row = {1'h1, 7'h03, 7'h04, 7'h06, 2'h0, 2'h1};
            // RQ6 address register compare
            AIT_OP_ADDR_COMPARE:         row = {1'h1, 7'h01, 7'h04, 7'h04, 2'h0, 2'h0};
            // RQ7 bounds check read
            AIT_OP_BOUNDS_CHECK:         row = {1'h1, 7'h10, 7'h12, 7'h12, 2'h1, 2'h0};
            // RQ8 word multiply
            AIT_OP_WORD_MULTIPLY:        row = {1'h1, 7'h19, 7'h1B, 7'h1C, 2'h0, 2'h0};
            // RQ9 long multiply
            AIT_OP_LONG_MULTIPLY:        row = {1'h1, 7'h29, 7'h2B, 7'h2C, 2'h0, 2'h0};
            // RQ10 unsigned word divide
            AIT_OP_UNSIGNED_WORD_DIVIDE: row = {1'h1, 7'h2A, 7'h2C, 7'h2C, 2'h0, 2'h0};
            // RQ11 unsigned long divide
            AIT_OP_UNSIGNED_LONG_DIVIDE: row = {1'h1, 7'h4C, 7'h4E, 7'h4F, 2'h0, 2'h0};
            // RQ12 signed word divide
            AIT_OP_SIGNED_WORD_DIVIDE:   row = {1'h1, 7'h36, 7'h38, 7'h39, 2'h0, 2'h0};
            // RQ13 signed long divide
            AIT_OP_SIGNED_LONG_DIVIDE:   row = {1'h1, 7'h58, 7'h5A, 7'h5B, 2'h0, 2'h0};
            // RQ16 decimal register, complete time
            AIT_OP_DECIMAL_REG:          row = {1'h0, 7'h04, 7'h04, 7'h05, 2'h0, 2'h0};
            // RQ17 decimal memory two reads
            AIT_OP_DECIMAL_MEM:          row = {1'h0, 7'h0E, 7'h10, 7'h11, 2'h2, 2'h1};
            // RQ18 extend register form
            AIT_OP_EXTEND_REG:           row = {1'h0, 7'h02, 7'h02, 7'h03, 2'h0, 2'h0};
            // RQ19 extend memory form
            AIT_OP_EXTEND_MEM:           row = {1'h0, 7'h0A, 7'h0C, 7'h0D, 2'h2, 2'h1};
            // RQ20 postincrement memory compare
            AIT_OP_MEM_COMPARE:          row = {1'h0, 7'h08, 7'h09, 7'h0A, 2'h2, 2'h0};
            // RQ21 register pack
            AIT_OP_BCD_PACK_REG:         row = {1'h0, 7'h03, 7'h06, 7'h07, 2'h0, 2'h0};
            // RQ21 register unpack
            AIT_OP_BCD_UNPACK_REG:       row = {1'h0, 7'h05, 7'h08, 7'h09, 2'h0, 2'h0};
            // RQ22 memory pack and unpack
            AIT_OP_BCD_PACK_MEM:         row = {1'h0, 7'h0B, 7'h0D, 7'h0D, 2'h1, 2'h1};
            default:                     row = {1'h1, 7'h00, 7'h02, 7'h03, 2'h0, 2'h0};
        endcase
        e.add_time = row[25];
        e.rd       = row[3:2];
        e.wr       = row[1:0];
        // RQ2 worst case holds the prefetch
        if (cse == AIT_CASE_BEST) begin
            e.total = row[24:18];
            e.pf    = AIT_NO_PF;
        end else if (cse == AIT_CASE_CACHE) begin
            e.total = row[17:11];
            e.pf    = AIT_NO_PF;
        end else begin
            e.total = row[10:4];
            e.pf    = AIT_ONE_PF;
        end
        return e;
    endfunction : ait_lookup

    // RQ3 address time added to table count when add_time is set
    function automatic logic [AIT_CNT_W-1:0] ait_span(input ait_entry_t                 e,
                                                      input logic [AIT_ADDR_TIME_W-1:0] at);
        logic [AIT_CNT_W-1:0] s;
        s = {2'h0, e.total};
        if (e.add_time) begin
            s = s + {1'h0, at};
        end
        if (s == '0) begin
            s = AIT_MIN_SPAN;
        end
        return s;
    endfunction : ait_span

endpackage : ait_pkg
`default_nettype wire

// ==== ait_timing_rom.sv ====
// timing table memory: one entry per operation class and case
// assumes the caller pulses rd_en for one cycle; data appear after that edge
`timescale 1ns/1ps
`default_nettype none
module ait_timing_rom
    import ait_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                rd_en,
    input  wire logic [AIT_OP_W-1:0] rd_op,
    input  wire logic [1:0]          rd_case,
    output var  ait_entry_t          entry_q
);

    // registered read, held until the next rd_en
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            entry_q <= '0;
        end else if (rd_en) begin
            entry_q <= ait_lookup(rd_op, rd_case);
        end
    end

endmodule : ait_timing_rom
`default_nettype wire

// ==== ait_alu_timing.sv ====
// alu instruction timer: paces arithmetic, immediate and decimal operations
// assumes the sequencer issues one operation at a time with its address time,
// and the bus interface serves each one-cycle read, prefetch and write pulse
// Function
// RQ1: bus cycles counted inside the total
// RQ2: worst case includes next prefetch
// RQ3: add address time to listed count
// RQ4: register alu ops take 0/2/3
// RQ5: memory alu ops 3/4/6 with write
// RQ6: address register compare takes 1/4/4
// RQ7: bounds check 16/18/18, one read
// RQ8: word multiply 25/27/28
// RQ9: long multiply 41/43/44
// RQ10: unsigned word divide 42/44/44
// RQ11: unsigned long divide 76/78/79
// RQ12: signed word divide 54/56/57
// RQ13: signed long divide 88/90/91
// RQ14: quick and immediate register ops 0/2/3
// RQ15: quick and immediate memory ops 3/4/6
// RQ16: register decimal 4/4/5, no address time
// RQ17: memory decimal 14/16/17, two reads, write
// RQ18: register extend ops 2/2/3
// RQ19: memory extend ops 10/12/13
// RQ20: memory compare 8/9/10, two reads
// RQ21: register pack 3/6/7, unpack 5/8/9
// RQ22: memory pack and unpack 11/13/13
// RQ23: completion pulse exactly at count end
`timescale 1ns/1ps
`default_nettype none
module ait_alu_timing
    import ait_pkg::*;
#(
    parameter int ADDR_TIME_W = AIT_ADDR_TIME_W
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   issue_valid,
    input  wire logic [AIT_OP_W-1:0]    issue_op,
    input  wire logic [1:0]             issue_case,
    input  wire logic [ADDR_TIME_W-1:0] addr_time,
    output logic                        issue_ready_q,
    output logic                        busy_q,
    output logic                        done_q,
    output logic                        rd_req_q,
    output logic                        pf_req_q,
    output logic                        wr_req_q
);

    generate
        if (ADDR_TIME_W < 1 || ADDR_TIME_W > AIT_ADDR_TIME_W) begin : g_bad_width
            $error("addr_time width out of range");
        end
    endgenerate

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } ait_state_t;

    ait_state_t                 state_q;
    ait_state_t                 state_d;
    ait_entry_t                 entry_q;
    logic [AIT_ADDR_TIME_W-1:0] addr_q;
    logic [AIT_CNT_W-1:0]       elap_q;
    logic [AIT_CNT_W-1:0]       span;
    logic                       take;
    logic                       last;

    assign take = issue_valid && (state_q == ST_IDLE);

    ait_timing_rom u_rom (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .rd_en    (take),
        .rd_op    (issue_op),
        .rd_case  (issue_case),
        .entry_q  (entry_q)
    );

    // RQ3 total is table count plus address time for entries with add_time set
    assign span = ait_span(entry_q, addr_q);
    assign last = (state_q == ST_RUN) && (elap_q == span - AIT_MIN_SPAN);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (last) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // capture the address time with the issue
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= '0;
        end else if (take) begin
            addr_q <= AIT_ADDR_TIME_W'(addr_time);
        end
    end

    // cycles elapsed since the issue
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            elap_q <= '0;
        end else if (take) begin
            elap_q <= '0;
        end else if (state_q == ST_RUN) begin
            elap_q <= elap_q + AIT_MIN_SPAN;
        end
    end

    // RQ23 completion and handshake
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_q        <= 1'b0;
            busy_q        <= 1'b0;
            issue_ready_q <= 1'b0;
        end else begin
            done_q        <= last;
            busy_q        <= (state_d == ST_RUN);
            issue_ready_q <= (state_d == ST_IDLE);
        end
    end

    // RQ1 bus cycles placed inside the total
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_req_q <= 1'b0;
            pf_req_q <= 1'b0;
            wr_req_q <= 1'b0;
        end else if (state_q == ST_RUN) begin
            rd_req_q <= elap_q < {{(AIT_CNT_W-AIT_BUS_W){1'b0}}, entry_q.rd};
            pf_req_q <= (entry_q.pf != '0) && (elap_q == span - AIT_PF_BACK);
            wr_req_q <= (entry_q.wr != '0) && (elap_q == span - AIT_WR_BACK);
        end else begin
            rd_req_q <= 1'b0;
            pf_req_q <= 1'b0;
            wr_req_q <= 1'b0;
        end
    end

    // checking helpers: expectations taken straight from the issue
    ait_entry_t           exp_q;
    logic [AIT_CNT_W-1:0] exp_span_q;
    logic [AIT_CNT_W-1:0] cyc_q;
    logic [AIT_BUS_W-1:0] rd_cnt_q;
    logic [AIT_BUS_W-1:0] pf_cnt_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_q      <= '0;
            exp_span_q <= '0;
            cyc_q      <= '0;
            rd_cnt_q   <= '0;
            pf_cnt_q   <= '0;
        end else if (take) begin
            exp_q      <= ait_lookup(issue_op, issue_case);
            exp_span_q <= ait_span(ait_lookup(issue_op, issue_case),
                                   AIT_ADDR_TIME_W'(addr_time));
            cyc_q      <= '0;
            rd_cnt_q   <= '0;
            pf_cnt_q   <= '0;
        end else begin
            cyc_q      <= cyc_q + AIT_MIN_SPAN;
            rd_cnt_q   <= rd_cnt_q + {1'b0, rd_req_q};
            pf_cnt_q   <= pf_cnt_q + {1'b0, pf_req_q};
        end
    end

    a_done_span: assert property ( // RQ23
        @(posedge core_clk) disable iff (!reset_n)
        done_q |-> (cyc_q == exp_span_q) && issue_ready_q && !busy_q
    ) else $error("completion not at expected count");

    a_addr_time_sum: assert property ( // RQ3
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_LONG_MULTIPLY && issue_case == AIT_CASE_BEST
            && addr_time == ADDR_TIME_W'(1)
        |=> !done_q [*8] ##35 done_q
    ) else $error("address time not added");

    a_bus_counts: assert property ( // RQ1
        @(posedge core_clk) disable iff (!reset_n)
        done_q |-> rd_cnt_q == exp_q.rd && wr_req_q == (exp_q.wr != '0)
    ) else $error("bus cycle count wrong");

    a_bus_inside: assert property ( // RQ1
        @(posedge core_clk) disable iff (!reset_n)
        (rd_req_q || pf_req_q || wr_req_q) |-> $past(busy_q)
    ) else $error("bus cycle outside operation");

    a_worst_prefetch: assert property ( // RQ2
        @(posedge core_clk) disable iff (!reset_n)
        done_q |-> pf_cnt_q == ((exp_q.pf != '0) ? AIT_ONE_PF : AIT_NO_PF)
    ) else $error("prefetch count wrong");

    a_reg_alu_worst: assert property ( // RQ4
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_REG_ALU && issue_case == AIT_CASE_WORST
            && addr_time == '0
        |=> !done_q [*2] ##1 (pf_req_q && !done_q) ##1 done_q
    ) else $error("register alu worst case not 3");

    a_mem_alu_write: assert property ( // RQ5
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_MEM_ALU && issue_case == AIT_CASE_WORST
            && addr_time == '0
        |-> ##6 pf_req_q ##1 (wr_req_q && done_q)
    ) else $error("memory alu worst case wrong");

    a_bounds_read: assert property ( // RQ7
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_BOUNDS_CHECK
        |-> ##2 rd_req_q ##1 !rd_req_q
    ) else $error("bounds check read missing");

    a_decimal_fixed: assert property ( // RQ16
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_DECIMAL_REG && issue_case == AIT_CASE_BEST
        |-> ##5 done_q
    ) else $error("decimal register time wrong");

    a_decimal_worst: assert property ( // RQ16
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_DECIMAL_REG && issue_case == AIT_CASE_WORST
        |=> !done_q [*4] ##1 (pf_req_q && !done_q) ##1 done_q
    ) else $error("decimal register worst case wrong");

    a_busy_hold: assert property ( // RQ23
        @(posedge core_clk) disable iff (!reset_n)
        take |=> busy_q && !issue_ready_q
    ) else $error("busy not raised on issue");

    a_decimal_mem: assert property ( // RQ17
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_DECIMAL_MEM && issue_case == AIT_CASE_WORST
        |-> ##2 rd_req_q ##1 rd_req_q ##1 !rd_req_q ##13 pf_req_q ##1 (wr_req_q && done_q)
    ) else $error("memory decimal worst case wrong");

    a_extend_mem: assert property ( // RQ19
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_EXTEND_MEM && issue_case == AIT_CASE_BEST
        |-> ##2 rd_req_q [*2] ##1 !rd_req_q ##7 (wr_req_q && done_q)
    ) else $error("memory extend best case wrong");

    a_mem_compare: assert property ( // RQ20
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_MEM_COMPARE && issue_case == AIT_CASE_CACHE
        |=> !done_q [*8] ##1 !done_q ##1 (done_q && !wr_req_q)
    ) else $error("memory compare cache case wrong");

    a_unpack_worst: assert property ( // RQ21
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_BCD_UNPACK_REG && issue_case == AIT_CASE_WORST
        |=> !done_q [*8] ##1 (pf_req_q && !done_q) ##1 done_q
    ) else $error("register unpack worst case wrong");

    a_pack_mem: assert property ( // RQ22
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_BCD_PACK_MEM && issue_case == AIT_CASE_CACHE
        |-> ##2 rd_req_q ##1 !rd_req_q ##11 (wr_req_q && done_q)
    ) else $error("memory pack cache case wrong");

    a_extend_reg: assert property ( // RQ18
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_EXTEND_REG && issue_case == AIT_CASE_BEST
        |=> !done_q [*2] ##1 done_q
    ) else $error("register extend best case wrong");

    c_word_divide: cover property (
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_UNSIGNED_WORD_DIVIDE && issue_case == AIT_CASE_CACHE
    );

    c_long_divide: cover property (
        @(posedge core_clk) disable iff (!reset_n)
        take && issue_op == AIT_OP_SIGNED_LONG_DIVIDE && issue_case == AIT_CASE_WORST
    );

    c_mem_decimal: cover property (
        @(posedge core_clk) disable iff (!reset_n)
        done_q && wr_req_q && rd_cnt_q == 2'h2
    );

    c_back_to_back: cover property (
        @(posedge core_clk) disable iff (!reset_n)
        done_q && take
    );

endmodule : ait_alu_timing
`default_nettype wire

// ==== ait_bus_model.sv ====
// bus interface model: serves the timer's read, prefetch and write pulses
// assumes one-cycle pulses with no acknowledge; counts restart after done
`timescale 1ns/1ps
`default_nettype none
module ait_bus_model (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       rd_req_q,
    input  wire logic       pf_req_q,
    input  wire logic       wr_req_q,
    input  wire logic       done_q,
    output logic [7:0]      rd_seen,
    output logic [7:0]      pf_seen,
    output logic [7:0]      wr_seen
);
    logic [7:0] rd_cnt_q;
    logic [7:0] pf_cnt_q;
    logic [7:0] wr_cnt_q;

    assign rd_seen = rd_cnt_q + {7'h00, rd_req_q};
    assign pf_seen = pf_cnt_q + {7'h00, pf_req_q};
    assign wr_seen = wr_cnt_q + {7'h00, wr_req_q};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_cnt_q <= 8'h00;
            pf_cnt_q <= 8'h00;
            wr_cnt_q <= 8'h00;
        end else if (done_q) begin
            rd_cnt_q <= 8'h00;
            pf_cnt_q <= 8'h00;
            wr_cnt_q <= 8'h00;
        end else begin
            rd_cnt_q <= rd_seen;
            pf_cnt_q <= pf_seen;
            wr_cnt_q <= wr_seen;
        end
    end
endmodule : ait_bus_model
`default_nettype wire

// ==== tb_top.sv ====
// testbench: issues every class in every case, back to back, random 4-bit address time except ops 0 and 1 (zero) and op 5 (one)
// assumes the timer and the bus model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ait_pkg::*;
    logic        core_clk;
    logic        reset_n;
    logic        issue_valid;
    logic [4:0]  issue_op;
    logic [1:0]  issue_case;
    logic [7:0]  addr_time;
    logic        issue_ready_q;
    logic        busy_q;
    logic        done_q;
    logic        rd_req_q;
    logic        pf_req_q;
    logic        wr_req_q;
    logic [7:0]  rd_seen;
    logic [7:0]  pf_seen;
    logic [7:0]  wr_seen;
    logic [31:0] notes[$];
    logic [31:0] nt;
    logic [31:0] rng;
    int          fail_count;
    int          n_compared;
    int          cyc;
    int          start;
    int best_t  [18] = '{0, 3, 1, 16, 25, 41, 42, 76, 54, 88, 4, 14, 2, 10, 8, 3, 5, 11};
    int cache_t [18] = '{2, 4, 4, 18, 27, 43, 44, 78, 56, 90, 4, 16, 2, 12, 9, 6, 8, 13};
    int worst_t [18] = '{3, 6, 4, 18, 28, 44, 44, 79, 57, 91, 5, 17, 3, 13, 10, 7, 9, 13};
    int rd_n    [18] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 2, 0, 2, 2, 0, 0, 1};
    int wr_n    [18] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 0, 1};

    ait_alu_timing i_ait_alu_timing (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .issue_valid   (issue_valid),
        .issue_op      (issue_op),
        .issue_case    (issue_case),
        .addr_time     (addr_time),
        .issue_ready_q (issue_ready_q),
        .busy_q        (busy_q),
        .done_q        (done_q),
        .rd_req_q      (rd_req_q),
        .pf_req_q      (pf_req_q),
        .wr_req_q      (wr_req_q)
    );

    ait_bus_model i_ait_bus_model (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .rd_req_q (rd_req_q),
        .pf_req_q (pf_req_q),
        .wr_req_q (wr_req_q),
        .done_q   (done_q),
        .rd_seen  (rd_seen),
        .pf_seen  (pf_seen),
        .wr_seen  (wr_seen)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic issue(input int op, input int cs, input logic [7:0] at);
        int   cls;
        int   t;
        int   n;
        logic taken;
        cls = (op > 17) ? 0 : op;
        t = (cs == 0) ? best_t[cls] : (cs == 1) ? cache_t[cls] : worst_t[cls];
        if (cls < 10) t = t + int'(at);
        if (t == 0) t = 1;
        @(negedge core_clk);
        issue_valid = 1'b1;
        issue_op    = 5'(op);
        issue_case  = 2'(cs);
        addr_time   = at;
        taken = 1'b0;
        for (n = 0; n < 200 && !taken; n++) begin
            @(posedge core_clk);
            taken = (issue_ready_q === 1'b1);
        end
        if (!taken) begin
            fail_count++;
            complete_run();
        end else begin
            notes.push_back({8'(t + 1), 8'(rd_n[cls]), 8'(cs >= 2), 8'(wr_n[cls])});
        end
    endtask : issue

    // monitor: done pulse closes the oldest note
    always @(posedge core_clk) begin
        if (reset_n && done_q === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                check(32'(cyc - start), {24'h0, nt[31:24]});
                check({24'h0, rd_seen}, {24'h0, nt[23:16]});
                check({24'h0, pf_seen}, {24'h0, nt[15:8]});
                check({24'h0, wr_seen}, {24'h0, nt[7:0]});
                check({30'h0, busy_q, issue_ready_q}, 32'h1);
            end
        end
        if (reset_n && issue_valid && issue_ready_q === 1'b1) start = cyc;
        cyc = cyc + 1;
    end

    initial begin
        int k;
        fail_count  = 0;
        n_compared  = 0;
        cyc         = 0;
        start       = 0;
        rng         = 32'h0A2FBAB0;
        reset_n     = 1'b0;
        issue_valid = 1'b0;
        issue_op    = 5'h00;
        issue_case  = 2'h0;
        addr_time   = 8'h00;
        repeat (5) @(negedge core_clk);
        check({31'h0, issue_ready_q}, 32'h0);
        reset_n = 1'b1;
        @(negedge core_clk);
        check({31'h0, issue_ready_q}, 32'h1);
        for (int cs = 0; cs < 4; cs++) begin
            for (int op = 0; op < 19; op++) begin
                rng = xorshift(rng);
                issue(op, cs, (op < 2) ? 8'h00 : (op == 5) ? 8'h01 : {4'h0, rng[3:0]});
            end
        end
        @(negedge core_clk);
        issue_valid = 1'b0;
        for (k = 0; k < 300 && notes.size() > 0; k++) @(negedge core_clk);
        if (notes.size() > 0) fail_count++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
